//--- include/wake_pkg.sv
// constants and types shared by the wake event status and enable block
package wake_pkg;

	// ======================================================
	// bus shape
	localparam int ADDR_W     = 7;
	localparam int DATA_W     = 32;
	localparam int BYTE_W     = 8;
	localparam int IDX_W      = 5;
	localparam int NUM_BYTES  = 5;
	localparam int NUM_SRC    = NUM_BYTES * BYTE_W;

	// ======================================================
	// register indices, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_STATUS_FIRST  = 5'h04;
	localparam logic [IDX_W-1:0] IDX_STATUS_SECOND = 5'h05;
	localparam logic [IDX_W-1:0] IDX_STATUS_THIRD  = 5'h06;
	localparam logic [IDX_W-1:0] IDX_STATUS_FOURTH = 5'h07;
	localparam logic [IDX_W-1:0] IDX_STATUS_FIFTH  = 5'h08;
	localparam logic [IDX_W-1:0] IDX_RESERVED_ZERO = 5'h09;
	localparam logic [IDX_W-1:0] IDX_ENABLE_FIRST  = 5'h0a;
	localparam logic [IDX_W-1:0] IDX_ENABLE_SECOND = 5'h0b;
	localparam logic [IDX_W-1:0] IDX_ENABLE_THIRD  = 5'h0c;
	localparam logic [IDX_W-1:0] IDX_ENABLE_FOURTH = 5'h0d;
	localparam logic [IDX_W-1:0] IDX_ENABLE_FIFTH  = 5'h0e;
	localparam logic [IDX_W-1:0] IDX_CONTROL       = 5'h0f;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS    = 5'h10;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK      = 5'h11;

	// ======================================================
	// reset values and fields
	localparam logic [BYTE_W-1:0]    RESET_BYTE      = 8'h00;
	localparam logic [NUM_SRC-1:0]   RESET_SOURCES   = 40'h00_0000_0000;
	localparam logic [NUM_BYTES-1:0] RESET_IRQ       = 5'h00;
	localparam logic [NUM_SRC-1:0]   SRC_VALID_MASK  = 40'hff_ffff_fffe;
	localparam int                   MASTER_EN_BIT   = 0;
	localparam int                   SMI_WAKE_BIT    = 3;

	// one byte per wake status register, lowest register in the low byte
	typedef struct packed {
		logic [BYTE_W-1:0] groupFive;
		logic [BYTE_W-1:0] groupThreeFourSix;
		logic [BYTE_W-1:0] groupTwoSmi;
		logic [BYTE_W-1:0] groupOne;
		logic [BYTE_W-1:0] ownSources;
	} wake_src_s;

endpackage

//--- rtl/wake_event_status_enable.sv
// wake event status, enables and low-active wake request output
`timescale 1ns/1ps

// Notes on behaviour
// - wake event sets its status bit, held
// - status records events regardless of enables
// - writing one to status bit clears it
// - writing zero to status bit: no change
// - status survives main, soft, hard reset
// - enables survive main, soft, hard reset
// - only standby power-on reset loads zeros
// - wake out when enabled status and master
// - disabled source updates status, no wake
// - second status byte is group one pins
// - third status: group two, bit3 smi
// - fourth status: group three, four, six
// - fifth status byte is group five pins
// - reserved slot always reads zero
// - first enable: bit0 reserved, own sources
module wake_event_status_enable
	import wake_pkg::*;
(
	input  wire logic                clock,
	input  wire logic                rst_n,
	input  wire logic [ADDR_W-1:0]   address,
	input  wire logic                read,
	input  wire logic                write,
	input  wire logic [DATA_W-1:0]   writedata,
	input  wire logic [DATA_W/8-1:0] byteenable,
	output logic      [DATA_W-1:0]   readdata,
	output logic                     waitrequest,
	input  wire wake_src_s           wakeIn,
	output logic                     wake_request_out_n,
	output logic                     irq
);

	// ======================================================
	// wake source break-out, one named wire per source
	// own byte bit 0 has no source and is tied low
	wire                ring_indicate_two;
	wire                ring_indicate_one;
	wire                keyboard_wake;
	wire                mouseWake;
	wire                specific_key_wake;
	wire                fan_speed_sense_one;
	wire                fan_speed_sense_two;

	wire                pin_b1_i0;
	wire                pin_b1_i1;
	wire                pin_b1_i2;
	wire                pin_b1_i3;
	wire                pin_b1_i4;
	wire                pin_b1_i5;
	wire                pin_b1_i6;
	wire                pin_b1_i7;

	wire                pin_b2_i0;
	wire                pin_b2_i1;
	wire                pin_b2_i2;
	wire                groupedSmiWake;
	wire                pin_b2_i4;
	wire                pin_b2_i5;
	wire                pin_b2_i6;
	wire                pin_b2_i7;

	wire                pin_b3_i0;
	wire                pin_b3_i1;
	wire                pin_b3_i2;
	wire                pin_b3_i3;
	wire                pin_b4_i1;
	wire                pin_b4_i3;
	wire                pin_b6_i0;
	wire                pin_b6_i1;

	wire                pin_b5_i0;
	wire                pin_b5_i1;
	wire                pin_b5_i2;
	wire                pin_b5_i3;
	wire                pin_b5_i4;
	wire                pin_b5_i5;
	wire                pin_b5_i6;
	wire                pin_b5_i7;
	wire [NUM_SRC-1:0]  rawSources;

	assign ring_indicate_two   = wakeIn.ownSources[1];
	assign ring_indicate_one   = wakeIn.ownSources[2];
	assign keyboard_wake       = wakeIn.ownSources[3];
	assign mouseWake           = wakeIn.ownSources[4];
	assign specific_key_wake   = wakeIn.ownSources[5];
	assign fan_speed_sense_one = wakeIn.ownSources[6];
	assign fan_speed_sense_two = wakeIn.ownSources[7];

	assign pin_b1_i0 = wakeIn.groupOne[0];
	assign pin_b1_i1 = wakeIn.groupOne[1];
	assign pin_b1_i2 = wakeIn.groupOne[2];
	assign pin_b1_i3 = wakeIn.groupOne[3];
	assign pin_b1_i4 = wakeIn.groupOne[4];
	assign pin_b1_i5 = wakeIn.groupOne[5];
	assign pin_b1_i6 = wakeIn.groupOne[6];
	assign pin_b1_i7 = wakeIn.groupOne[7];

	// group two, smi at bit 3
	assign pin_b2_i0      = wakeIn.groupTwoSmi[0];
	assign pin_b2_i1      = wakeIn.groupTwoSmi[1];
	assign pin_b2_i2      = wakeIn.groupTwoSmi[2];
	assign groupedSmiWake = wakeIn.groupTwoSmi[SMI_WAKE_BIT];
	assign pin_b2_i4      = wakeIn.groupTwoSmi[4];
	assign pin_b2_i5      = wakeIn.groupTwoSmi[5];
	assign pin_b2_i6      = wakeIn.groupTwoSmi[6];
	assign pin_b2_i7      = wakeIn.groupTwoSmi[7];

	assign pin_b3_i0 = wakeIn.groupThreeFourSix[0];
	assign pin_b3_i1 = wakeIn.groupThreeFourSix[1];
	assign pin_b3_i2 = wakeIn.groupThreeFourSix[2];
	assign pin_b3_i3 = wakeIn.groupThreeFourSix[3];
	assign pin_b4_i1 = wakeIn.groupThreeFourSix[4];
	assign pin_b4_i3 = wakeIn.groupThreeFourSix[5];
	assign pin_b6_i0 = wakeIn.groupThreeFourSix[6];
	assign pin_b6_i1 = wakeIn.groupThreeFourSix[7];

	assign pin_b5_i0 = wakeIn.groupFive[0];
	assign pin_b5_i1 = wakeIn.groupFive[1];
	assign pin_b5_i2 = wakeIn.groupFive[2];
	assign pin_b5_i3 = wakeIn.groupFive[3];
	assign pin_b5_i4 = wakeIn.groupFive[4];
	assign pin_b5_i5 = wakeIn.groupFive[5];
	assign pin_b5_i6 = wakeIn.groupFive[6];
	assign pin_b5_i7 = wakeIn.groupFive[7];

	// order follows the register layout, highest bit first
	assign rawSources = {
		pin_b5_i7,
		pin_b5_i6,
		pin_b5_i5,
		pin_b5_i4,
		pin_b5_i3,
		pin_b5_i2,
		pin_b5_i1,
		pin_b5_i0,
		pin_b6_i1,
		pin_b6_i0,
		pin_b4_i3,
		pin_b4_i1,
		pin_b3_i3,
		pin_b3_i2,
		pin_b3_i1,
		pin_b3_i0,
		pin_b2_i7,
		pin_b2_i6,
		pin_b2_i5,
		pin_b2_i4,
		groupedSmiWake,
		pin_b2_i2,
		pin_b2_i1,
		pin_b2_i0,
		pin_b1_i7,
		pin_b1_i6,
		pin_b1_i5,
		pin_b1_i4,
		pin_b1_i3,
		pin_b1_i2,
		pin_b1_i1,
		pin_b1_i0,
		fan_speed_sense_two,
		fan_speed_sense_one,
		specific_key_wake,
		mouseWake,
		keyboard_wake,
		ring_indicate_one,
		ring_indicate_two,
		1'b0
	};

	// ======================================================
	// input synchronisers
	// pulses shorter than about two clocks can be missed
	logic [NUM_SRC-1:0] syncA;
	logic [NUM_SRC-1:0] syncB;
	logic [NUM_SRC-1:0] syncC;
	logic [NUM_SRC-1:0] filtered;
	wire  [NUM_SRC-1:0] agree;
	wire  [NUM_SRC-1:0] next_filtered;
	wire  [NUM_SRC-1:0] wakeEvent;

	assign agree         = ~(syncB ^ syncC);
	assign next_filtered = (agree & syncB) | (~agree & filtered);
	assign wakeEvent     = next_filtered & ~filtered & SRC_VALID_MASK;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			syncA    <= RESET_SOURCES;
			syncB    <= RESET_SOURCES;
			syncC    <= RESET_SOURCES;
			filtered <= RESET_SOURCES;
		end
		else
		begin
			syncA    <= rawSources;
			syncB    <= syncA;
			syncC    <= syncB;
			filtered <= next_filtered;
		end
	end

	// ======================================================
	// bus slave: one wait state per access
	logic                    ack;
	logic [NUM_BYTES-1:0]    irqReadSnap;
	wire                     request;
	wire  [IDX_W-1:0]        index;
	wire                     doWrite;
	wire                     doRead;
	wire  [BYTE_W-1:0]       wrByte;
	wire  [BYTE_W-1:0]       readByte;

	assign request     = read | write;
	assign waitrequest = request & ~ack;
	assign index       = address[ADDR_W-1:2];
	assign doWrite     = write & ack & byteenable[0];
	assign doRead      = read & ack;
	assign wrByte      = writedata[BYTE_W-1:0];

	// ======================================================
	// register hits outside the byte loop
	function automatic logic regHit(input logic [IDX_W-1:0] idx,
		input logic [IDX_W-1:0] want);
		regHit = (idx == want);
	endfunction

	wire                     hitControl;
	wire                     hitIrqStatus;
	wire                     hitIrqMask;
	wire                     writeControl;
	wire                     writeIrqMask;

	assign hitControl   = regHit(index, IDX_CONTROL);
	assign hitIrqStatus = regHit(index, IDX_IRQ_STATUS);
	assign hitIrqMask   = regHit(index, IDX_IRQ_MASK);
	assign writeControl = doWrite & hitControl;
	assign writeIrqMask = doWrite & hitIrqMask;

	// ======================================================
	// status and enable bytes
	logic [NUM_SRC-1:0]   status;
	logic [NUM_SRC-1:0]   enable;
	wire  [NUM_SRC-1:0]   next_status;
	wire  [NUM_SRC-1:0]   next_enable;
	wire  [NUM_BYTES-1:0] byteEvent;
	logic [BYTE_W-1:0]    rdChain [NUM_BYTES+1];

	genvar i;
	generate
		for (i = 0; i < NUM_BYTES; i++)
		begin : g_byte
			localparam logic [IDX_W-1:0] SIDX =
				IDX_STATUS_FIRST + IDX_W'(i);
			localparam logic [IDX_W-1:0] EIDX =
				IDX_ENABLE_FIRST + IDX_W'(i);
			localparam logic [BYTE_W-1:0] VMASK =
				SRC_VALID_MASK[i*BYTE_W +: BYTE_W];
			wire [BYTE_W-1:0] clrMask;
			wire [BYTE_W-1:0] curStatus;
			wire [BYTE_W-1:0] curEnable;
			assign curStatus = status[i*BYTE_W +: BYTE_W];
			assign curEnable = enable[i*BYTE_W +: BYTE_W];
			assign clrMask =
				(doWrite && index == SIDX) ? wrByte : RESET_BYTE;
			assign next_status[i*BYTE_W +: BYTE_W] =
				(curStatus & ~clrMask) |
				wakeEvent[i*BYTE_W +: BYTE_W];
			assign next_enable[i*BYTE_W +: BYTE_W] =
				(doWrite && index == EIDX) ? (wrByte & VMASK)
				: curEnable;
			assign byteEvent[i] = |wakeEvent[i*BYTE_W +: BYTE_W];
			assign rdChain[i+1] = rdChain[i] |
				((index == SIDX) ? curStatus : RESET_BYTE) |
				((index == EIDX) ? curEnable : RESET_BYTE);
		end
	endgenerate

	// ======================================================
	// control, interrupt and output
	logic                 masterEnable;
	logic [NUM_BYTES-1:0] irqStatus;
	logic [NUM_BYTES-1:0] irqMask;
	wire  [NUM_BYTES-1:0] irqClr;
	wire  [NUM_BYTES-1:0] next_irqStatus;
	wire                  next_wakeOut_n;

	// clear only what the read returned, so a late event survives
	assign irqClr = (doRead && hitIrqStatus) ?
		irqReadSnap : RESET_IRQ;
	assign next_irqStatus = (irqStatus & ~irqClr) | byteEvent;

	assign next_wakeOut_n = ~(masterEnable & (|(status & enable)));

	assign rdChain[0] =
		(hitControl ?
			{7'h00, masterEnable} : RESET_BYTE) |
		(hitIrqStatus ?
			{3'h0, irqStatus} : RESET_BYTE) |
		(hitIrqMask ?
			{3'h0, irqMask} : RESET_BYTE);
	assign readByte = rdChain[NUM_BYTES];

	assign irq = |(irqStatus & irqMask);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack         <= 1'b0;
			readdata    <= '0;
			irqReadSnap <= RESET_IRQ;
		end
		else
		begin
			ack <= request & ~ack;
			if (request && !ack)
			begin
				readdata    <= {24'h000000, readByte};
				irqReadSnap <= irqStatus;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status             <= RESET_SOURCES;
			enable             <= RESET_SOURCES;
			masterEnable       <= 1'b0;
			irqStatus          <= RESET_IRQ;
			irqMask            <= RESET_IRQ;
			wake_request_out_n <= 1'b1;
		end
		else
		begin
			status             <= next_status;
			enable             <= next_enable;
			irqStatus          <= next_irqStatus;
			wake_request_out_n <= next_wakeOut_n;
			if (writeControl)
				masterEnable <= wrByte[MASTER_EN_BIT];
			if (writeIrqMask)
				irqMask <= wrByte[NUM_BYTES-1:0];
		end
	end

endmodule

//--- test/wake_event_status_enable_properties.sv
// port checker for the wake event status and enable block
`timescale 1ns/1ps
module wake_event_status_enable_properties
	import wake_pkg::*;
(
	input wire logic                clock,
	input wire logic                rst_n,
	input wire logic [ADDR_W-1:0]   address,
	input wire logic                read,
	input wire logic                write,
	input wire logic [DATA_W-1:0]   writedata,
	input wire logic [DATA_W/8-1:0] byteenable,
	input wire logic [DATA_W-1:0]   readdata,
	input wire logic                waitrequest,
	input wire wake_src_s           wakeIn,
	input wire logic                wake_request_out_n,
	input wire logic                irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// ==========================================
	// completed bus steps
	sequence rdDone(idx);
		read && !waitrequest && address[6:2] == idx;
	endsequence
	sequence wrDone(idx, v);
		write && !waitrequest && address[6:2] == idx
			&& byteenable[0] && writedata[7:0] == v;
	endsequence
	// ==========================================
	// properties
	chk_wait_first: assert property (
		$rose(read | write) |-> waitrequest)
		else $error("request answered with no wait state");
	chk_wait_one: assert property (
		(read | write) && waitrequest |=> !waitrequest)
		else $error("more than one wait state");
	chk_upper_zero: assert property (
		readdata[31:8] == 24'h0)
		else $error("upper read lanes not zero");
	chk_reserved_zero: assert property (
		rdDone(IDX_RESERVED_ZERO) |-> readdata == 32'h0)
		else $error("reserved slot read not zero");
	chk_unmapped_zero: assert property (
		rdDone(5'h1f) |-> readdata == 32'h0)
		else $error("unmapped read not zero");
	chk_enable_bit0: assert property (
		rdDone(IDX_ENABLE_FIRST) |-> !readdata[0])
		else $error("reserved enable bit reads one");
	chk_master_off: assert property (
		wrDone(IDX_CONTROL, 8'h00) |-> ##[1:3] wake_request_out_n)
		else $error("wake out kept low with master off");
	chk_mask_off: assert property (
		wrDone(IDX_IRQ_MASK, 8'h00) |-> ##[1:3] !irq)
		else $error("irq kept high with mask clear");
endmodule

//--- test/chipset_wake_input.sv
// chipset side: counts requests on the low-active wake line
`timescale 1ns/1ps
module chipset_wake_input
(
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic wake_request_out_n,
	output int        wakeCount
);
	// a falling edge starts one request
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			wakeCount <= 0;
		else if ($fell(wake_request_out_n))
			wakeCount <= wakeCount + 1;
	end
endmodule

//--- test/wake_event_status_enable_test.sv
// bench for the wake event block, with checker bind
`timescale 1ns/1ps
module wake_event_status_enable_test
	import wake_pkg::*;
;
	typedef struct packed {logic [4:0] idx; logic [7:0] wd, rd;} row_s;
	logic              clock = 0, rst_n = 0, read = 0, write = 0;
	logic [ADDR_W-1:0] address = '0;
	logic [DATA_W-1:0] writedata = '0, readdata;
	logic [3:0]        byteenable = 4'h1;
	logic              waitrequest, wake_request_out_n, irq;
	wake_src_s         wakeIn = '0;
	logic [7:0]        q, m;
	logic [4:0]        s;
	logic [39:0]       en = {24'h0, 8'ha5, 8'hfe};
	int                n_fail = 0, tests_run = 0, cyc = 0, expWakes = 1;
	int                wakeCount;
	row_s              rows[6] = '{'{5'h0a, 8'hff, 8'hfe},
		'{5'h09, 8'hff, 8'h00}, '{5'h1f, 8'hff, 8'h00},
		'{5'h0b, 8'ha5, 8'ha5}, '{5'h0f, 8'h01, 8'h01},
		'{5'h11, 8'h1f, 8'h1f}};
	wake_event_status_enable i_dut (.*);
	chipset_wake_input i_host (.*);
	always #12.5 clock = ~clock;
	// ==========================================
	// bus and compare tasks
	task automatic bus(input logic w, input logic [4:0] idx,
		input logic [7:0] d, output logic [7:0] r);
		write <= w;
		read <= !w;
		address <= {idx, 2'b00};
		writedata <= {24'h0, d};
		do @(posedge clock); while (waitrequest !== 1'b0);
		r = readdata[7:0];
		write <= 1'b0;
		read <= 1'b0;
		@(posedge clock);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, v);
		tests_run++;
		if (v !== e)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, v);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// hang guard, the run needs under 3000 cycles
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			n_fail++;
			tally_and_finish();
		end
	end
	// ==========================================
	// main sequence
	initial
	begin
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		foreach (rows[i])
		begin
			bus(0, rows[i].idx, 8'h00, q);
			chk("reset value", 0, q);
			bus(1, rows[i].idx, rows[i].wd, q);
			bus(0, rows[i].idx, 8'h00, q);
			chk("read back", rows[i].rd, q);
		end
		// bit 0 of the first byte has no source
		for (int b = 1; b < NUM_SRC; b++)
		begin
			m = 8'h01 << (b % 8);
			s = IDX_STATUS_FIRST + 5'(b / 8);
			wakeIn[b] <= 1'b1;
			repeat (6) @(posedge clock);
			wakeIn[b] <= 1'b0;
			expWakes += en[b];
			chk("wake out", !en[b], wake_request_out_n);
			chk("irq set", 1, irq);
			bus(1, s, ~m, q);
			bus(0, s, 8'h00, q);
			chk("status kept", m, q);
			bus(1, s, m, q);
			bus(0, s, 8'h00, q);
			chk("status clear", 0, q);
			bus(0, IDX_IRQ_STATUS, 8'h00, q);
			chk("irq status", 8'h01 << (b / 8), q);
			chk("wake released", 1, wake_request_out_n);
			chk("irq clear", 0, irq);
		end
		bus(1, IDX_IRQ_MASK, 8'h00, q);
		wakeIn[8] <= 1'b1;
		repeat (6) @(posedge clock);
		chk("irq masked", 0, irq);
		chk("wake on", 0, wake_request_out_n);
		bus(1, IDX_CONTROL, 8'h00, q);
		@(posedge clock);
		chk("master off", 1, wake_request_out_n);
		bus(0, IDX_STATUS_SECOND, 8'h00, q);
		chk("status no master", 1, q);
		chk("request count", expWakes, wakeCount);
		// a write with lane 0 disabled is ignored
		byteenable <= 4'h0;
		bus(1, IDX_CONTROL, 8'h01, q);
		byteenable <= 4'h1;
		bus(0, IDX_CONTROL, 8'h00, q);
		chk("lane off write", 0, q);
		// mid-run standby reset, inputs quiet first
		wakeIn[8] <= 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b0;
		@(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		bus(0, IDX_STATUS_SECOND, 8'h00, q);
		chk("status after reset", 0, q);
		bus(0, IDX_ENABLE_FIRST, 8'h00, q);
		chk("enable after reset", 0, q);
		tally_and_finish();
	end
endmodule
bind wake_event_status_enable wake_event_status_enable_properties i_chk (.*);
